// File: pvrb_bank.sv
`timescale 1ns/100ps
`default_nettype none
module pvrb_bank
  import pvrb_pkg::*;
#(
  parameter int                     VERSION_REGS_LEVEL      = LVL_FULL,
  parameter int                     DATA_WIDTH              = DATA_NARROW,
  parameter int                     ADDR_WIDTH              = ADDR_NARROW_MAX,
  parameter int                     MEM_MGMT_LEVEL          = MMU_NONE,
  parameter bit                     HAS_BARREL_SHIFTER      = 1'b0,
  parameter bit                     HAS_DIVIDER             = 1'b0,
  parameter int                     HW_MUL_LEVEL            = MUL_NONE,
  parameter int                     FLOAT_UNIT_LEVEL        = FPU_NONE,
  parameter bit                     USES_ANY_TRAPS          = 1'b0,
  parameter bit                     HAS_INSTR_CACHE         = 1'b0,
  parameter bit                     HAS_DATA_CACHE          = 1'b0,
  parameter bit                     HAS_BRANCH_TARGET_CACHE = 1'b0,
  parameter bit                     FAULT_TOLERANT_FLAG     = 1'b0,
  parameter bit                     STACK_GUARD_FLAG        = 1'b0,
  parameter bit                     BYTE_SWAP_INSTR_FLAG    = 1'b0,
  // arbitrary value, not tied to any real release
  parameter logic [BYTE_W-1:0]      RELEASE_CODE            = 8'h5a,
  parameter logic [BYTE_W-1:0]      CUSTOM_VALUE_A_PARAM    = 8'h00,
  parameter logic [WORD_W-1:0]      CUSTOM_VALUE_B_PARAM    = 32'h0000_0000,
  // registers two to twelve, register n at [(n-2)*64 +: 64]
  parameter logic [11*DWORD_W-1:0]  OTHER_REGS_VALUE        = '0
)(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               rd_req,
  input  wire logic               rd_ext,
  input  wire logic [SEL_W-1:0]   special_reg_selector,
  output logic                    rd_valid,
  output logic                    rd_hit,
  output logic      [DWORD_W-1:0] rd_data,
  output logic                    status_version_present_bit
);

  // build-time decode of the read path options
  localparam bit WIDE_MODE   = (DATA_WIDTH == DATA_WIDE);
  localparam bit ADDR_EXT    = (DATA_WIDTH == DATA_NARROW) && (ADDR_WIDTH > ADDR_NARROW_MAX);
  localparam bit PHYS_ADDR_EXTENSION = ADDR_EXT && (MEM_MGMT_LEVEL == MMU_FULL);
  localparam bit HAS_MEM_MANAGER     = (MEM_MGMT_LEVEL > MMU_NONE);
  localparam bit CFG_FULL    = (VERSION_REGS_LEVEL == LVL_FULL);

  // number of implemented registers for the chosen level
  localparam logic [CNT_W-1:0] REG_COUNT =
    (VERSION_REGS_LEVEL == LVL_FULL)  ? CNT_W'(NUM_FULL)  :
    (VERSION_REGS_LEVEL == LVL_BASIC) ? CNT_W'(NUM_BASIC) : CNT_W'(NUM_NONE);

  // presence is a build fact, not a register: no version registers, bit low
  assign status_version_present_bit = (REG_COUNT != CNT_W'(NUM_NONE));

  // feature word packing
  pvrb_word0_if w0 ();
  logic [FLAG_CNT-1:0] flags;

  always_comb begin
    flags              = '0;
    flags[POS_CFG]     = CFG_FULL;
    flags[POS_BARREL]  = HAS_BARREL_SHIFTER;
    flags[POS_DIV]     = HAS_DIVIDER;
    flags[POS_MUL]     = (HW_MUL_LEVEL > MUL_NONE);
    flags[POS_FPU]     = (FLOAT_UNIT_LEVEL > FPU_NONE);
    flags[POS_TRAPS]   = USES_ANY_TRAPS || HAS_MEM_MANAGER;
    flags[POS_ICACHE]  = HAS_INSTR_CACHE;
    flags[POS_DCACHE]  = HAS_DATA_CACHE;
    flags[POS_MMU]     = HAS_MEM_MANAGER;
    flags[POS_BTC]     = HAS_BRANCH_TARGET_CACHE;
    flags[POS_ENDIAN]  = ENDIAN_LITTLE;
    flags[POS_FT]      = FAULT_TOLERANT_FLAG;
    flags[POS_STACK_GUARD_FLAG]   = STACK_GUARD_FLAG;
    flags[POS_BYTE_SWAP_INSTR_FLAG]   = BYTE_SWAP_INSTR_FLAG;
    flags[POS_WIDE]    = WIDE_MODE;
    flags[POS_RSVD]    = RSVD_VALUE;
  end

  assign w0.flags          = flags;
  assign w0.release_code   = RELEASE_CODE;
  assign w0.custom_value_a = CUSTOM_VALUE_A_PARAM;

  pvrb_word0_pack u_pack (
    .f (w0.packer)
  );

  // constant bank; no write port exists, and reset never touches it
  logic [DWORD_W-1:0] bank [NUM_FULL];

  for (genvar n = 0; n < NUM_FULL; n++) begin : g_bank
    if (n == IDX_FEATURES) begin : g_w0
      assign bank[n] = {{(DWORD_W-WORD_W){1'b0}}, w0.word};
    end else if (n == IDX_USER) begin : g_w1
      assign bank[n] = {{(DWORD_W-WORD_W){1'b0}}, CUSTOM_VALUE_B_PARAM};
    end else begin : g_wn
      assign bank[n] = OTHER_REGS_VALUE[(n-2)*DWORD_W +: DWORD_W];
    end
  end

  // selector decode
  logic [IDX_W-1:0]  sel_idx;
  logic              sel_base_ok;
  logic              sel_hit;
  logic              idx_is_wide;
  logic              idx_has_upper;

  assign sel_idx     = special_reg_selector[IDX_W-1:0];
  assign sel_base_ok = (special_reg_selector[SEL_W-1 -: BASE_W] == SEL_BASE);
  // registers beyond the level's count simply do not answer
  assign sel_hit     = sel_base_ok && ({1'b0, sel_idx} < REG_COUNT);

  // registers that can exceed 32 bits; register 12 is only wide in a 64-bit build,
  // elsewhere it reads through the ordinary low-half path like the rest
  assign idx_is_wide = (sel_idx == IDX_PAE_LO) || (sel_idx == IDX_PAE_HI) ||
                       (sel_idx == IDX_AEXT_LO) || (sel_idx == IDX_AEXT_HI) ||
                       (sel_idx == IDX_WIDE_EXTRA);

  // registers whose high half is reached by the extended read
  assign idx_has_upper =
    (ADDR_EXT && ((sel_idx == IDX_AEXT_LO) || (sel_idx == IDX_AEXT_HI))) ||
    (PHYS_ADDR_EXTENSION && ((sel_idx == IDX_PAE_LO) || (sel_idx == IDX_PAE_HI)));

  // read data selection; unselected or missing registers return zero
  logic [DWORD_W-1:0] rd_data_nxt;
  logic [DWORD_W-1:0] entry;

  always_comb begin
    entry       = bank[sel_idx < IDX_W'(NUM_FULL) ? sel_idx : IDX_FEATURES];
    rd_data_nxt = '0;
    if (sel_hit) begin
      if (rd_ext) begin
        // extended read only carries a high half where one exists
        if (idx_has_upper) begin
          rd_data_nxt = {{(DWORD_W-WORD_W){1'b0}}, entry[DWORD_W-1 -: WORD_W]};
        end
      end else if (WIDE_MODE && idx_is_wide) begin
        rd_data_nxt = entry;
      end else begin
        rd_data_nxt = {{(DWORD_W-WORD_W){1'b0}}, entry[WORD_W-1:0]};
      end
    end
  end

  // read strobe, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
    end
  end

  // hit flag; a miss tells the core the selector names nothing here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_hit <= 1'b0;
    end else begin
      rd_hit <= rd_req && sel_hit;
    end
  end

  // data is held between reads so a slow consumer can sample late
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_req) begin
      rd_data <= rd_data_nxt;
    end
  end

  // read port checks; all but the idle, reset and status checks look at the answer one cycle after its request
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  level_none_a: assert property (
    (REG_COUNT == CNT_W'(NUM_NONE)) && rd_req |=> !rd_hit && !status_version_present_bit
  ) else $error("read answered with no version registers built");

  level_basic_a: assert property (
    (VERSION_REGS_LEVEL == LVL_BASIC) && rd_req && sel_base_ok && (sel_idx != IDX_FEATURES)
    |=> !rd_hit && (rd_data == '0)
  ) else $error("basic level answered a register other than zero");

  level_full_a: assert property (
    CFG_FULL && rd_req && sel_base_ok |=> rd_hit == ($past(sel_idx) <= IDX_WIDE_EXTRA)
  ) else $error("full level hit does not match register range");

  selector_base_a: assert property (
    rd_req && !sel_base_ok |=> rd_valid && !rd_hit && (rd_data == '0)
  ) else $error("foreign selector produced an answer");

  addr_ext_split_a: assert property (
    ADDR_EXT && rd_req && rd_ext && sel_hit && (sel_idx == IDX_AEXT_LO)
    |=> rd_data[WORD_W-1:0] == bank[IDX_AEXT_LO][DWORD_W-1 -: WORD_W]
  ) else $error("extended read of address register lost its high half");

  phys_ext_split_a: assert property (
    PHYS_ADDR_EXTENSION && rd_req && !rd_ext && sel_hit && (sel_idx == IDX_PAE_HI)
    |=> rd_data == {{(DWORD_W-WORD_W){1'b0}}, bank[IDX_PAE_HI][WORD_W-1:0]}
  ) else $error("normal read of extension register not low half");

  wide_whole_a: assert property (
    WIDE_MODE && rd_req && !rd_ext && sel_hit && (sel_idx == IDX_WIDE_EXTRA)
    |=> rd_data == bank[IDX_WIDE_EXTRA]
  ) else $error("wide register not returned whole");

  // feature word fields, seen on a normal read of register zero; the register one word likewise
  cfg_level_a: assert property (
    rd_req && !rd_ext && sel_hit && (sel_idx == IDX_FEATURES)
    |=> rd_data[WORD_W-1-POS_CFG] == CFG_FULL
  ) else $error("level bit wrong in feature word");

  unit_bits_a: assert property (
    rd_req && !rd_ext && sel_hit && (sel_idx == IDX_FEATURES)
    |=> (rd_data[WORD_W-1-POS_BARREL] == HAS_BARREL_SHIFTER) &&
        (rd_data[WORD_W-1-POS_DIV] == HAS_DIVIDER) &&
        (rd_data[WORD_W-1-POS_MUL] == (HW_MUL_LEVEL > MUL_NONE)) &&
        (rd_data[WORD_W-1-POS_FPU] == (FLOAT_UNIT_LEVEL > FPU_NONE))
  ) else $error("unit presence bits wrong");

  trap_bit_a: assert property (
    rd_req && !rd_ext && sel_hit && (sel_idx == IDX_FEATURES)
    |=> rd_data[WORD_W-1-POS_TRAPS] == (USES_ANY_TRAPS || HAS_MEM_MANAGER)
  ) else $error("trap bit wrong");

  cache_bits_a: assert property (
    rd_req && !rd_ext && sel_hit && (sel_idx == IDX_FEATURES)
    |=> (rd_data[WORD_W-1-POS_ICACHE] == HAS_INSTR_CACHE) &&
        (rd_data[WORD_W-1-POS_DCACHE] == HAS_DATA_CACHE) &&
        (rd_data[WORD_W-1-POS_MMU] == HAS_MEM_MANAGER) &&
        (rd_data[WORD_W-1-POS_BTC] == HAS_BRANCH_TARGET_CACHE)
  ) else $error("cache or mmu presence bits wrong");

  endian_bit_a: assert property (
    rd_req && !rd_ext && sel_hit && (sel_idx == IDX_FEATURES)
    |=> rd_data[WORD_W-1-POS_ENDIAN]
  ) else $error("byte order bit not little endian");

  misc_bits_a: assert property (
    rd_req && !rd_ext && sel_hit && (sel_idx == IDX_FEATURES)
    |=> (rd_data[WORD_W-1-POS_WIDE] == WIDE_MODE) && !rd_data[WORD_W-1-POS_RSVD] &&
        (rd_data[WORD_W-1-POS_BYTE_SWAP_INSTR_FLAG] == BYTE_SWAP_INSTR_FLAG) &&
        (rd_data[WORD_W-1-POS_FT] == FAULT_TOLERANT_FLAG) &&
        (rd_data[WORD_W-1-POS_STACK_GUARD_FLAG] == STACK_GUARD_FLAG)
  ) else $error("option bits or reserved bit wrong");

  release_code_a: assert property (
    rd_req && !rd_ext && sel_hit && (sel_idx == IDX_FEATURES)
    |=> rd_data[WORD_W-1-POS_RELEASE -: BYTE_W] == RELEASE_CODE
  ) else $error("release code field wrong");

  custom_a_field_a: assert property (
    rd_req && !rd_ext && sel_hit && (sel_idx == IDX_FEATURES)
    |=> (rd_data[BYTE_W-1:0] == CUSTOM_VALUE_A_PARAM) && (rd_data[DWORD_W-1:WORD_W] == '0)
  ) else $error("first custom value field wrong");

  custom_b_word_a: assert property (
    rd_req && !rd_ext && sel_hit && (sel_idx == IDX_USER)
    |=> rd_data == {{(DWORD_W-WORD_W){1'b0}}, CUSTOM_VALUE_B_PARAM}
  ) else $error("second custom value word wrong");

  msb_first_a: assert property (
    rd_req && !rd_ext && sel_hit && (sel_idx == IDX_FEATURES)
    |=> rd_data[WORD_W-1] == CFG_FULL && rd_data[WORD_W-1-FLAG_CNT+1] == RSVD_VALUE
  ) else $error("feature word bit order reversed");

  // same selector and read kind twice in a row must give the same word
  stable_bank_a: assert property (
    rd_req ##1 rd_req && $stable(special_reg_selector) && $stable(rd_ext)
    |=> $stable(rd_data)
  ) else $error("version register contents changed between reads");

  valid_pulse_a: assert property (
    rd_req |=> rd_valid && (rd_hit == $past(sel_hit))
  ) else $error("read strobe missing one cycle after request");

  // without a request the strobes stay low and the last answer stands
  idle_quiet_a: assert property (
    !rd_req |=> !rd_valid && !rd_hit && $stable(rd_data)
  ) else $error("read port moved with no request");

  // reset clears the read port whatever the request lines do
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n |=> !rd_valid && !rd_hit && (rd_data == '0)
  ) else $error("read port not cleared by reset");

  // the status bit follows the build level alone
  status_level_a: assert property (
    status_version_present_bit == (VERSION_REGS_LEVEL != LVL_NONE)
  ) else $error("version present bit disagrees with level");

  basic_zero_a: assert property (
    (VERSION_REGS_LEVEL == LVL_BASIC) && rd_req && sel_base_ok && (sel_idx == IDX_FEATURES)
    |=> rd_hit
  ) else $error("basic level did not answer register zero");

  // high halves, and the zero answer where no high half exists
  addr_ext_hi_a: assert property (
    ADDR_EXT && rd_req && rd_ext && sel_hit && (sel_idx == IDX_AEXT_HI)
    |=> rd_data == {{(DWORD_W-WORD_W){1'b0}}, bank[IDX_AEXT_HI][DWORD_W-1 -: WORD_W]}
  ) else $error("extended read of second address register wrong");

  phys_ext_hi_a: assert property (
    PHYS_ADDR_EXTENSION && rd_req && rd_ext && sel_hit && (sel_idx == IDX_PAE_LO)
    |=> rd_data == {{(DWORD_W-WORD_W){1'b0}}, bank[IDX_PAE_LO][DWORD_W-1 -: WORD_W]}
  ) else $error("extended read of extension register wrong");

  ext_no_upper_a: assert property (
    rd_req && rd_ext && sel_hit && !idx_has_upper |=> rd_hit && (rd_data == '0)
  ) else $error("extended read answered a register with no high half");

  narrow_upper_a: assert property (
    !WIDE_MODE && rd_req |=> rd_data[DWORD_W-1 -: WORD_W] == '0
  ) else $error("narrow build drove upper data bits");

  // wide build: every wide register read whole on a normal read, the rest zero above 32 bits
  wide_all_a: assert property (
    WIDE_MODE && rd_req && !rd_ext && sel_hit && idx_is_wide |=> rd_data == bank[$past(sel_idx)]
  ) else $error("wide register not returned whole");

  wide_rest_a: assert property (
    WIDE_MODE && rd_req && !idx_is_wide |=> rd_data[DWORD_W-1 -: WORD_W] == '0
  ) else $error("narrow register showed upper bits in wide build");

endmodule
`default_nettype wire

// File: pvrb_pkg.sv
`default_nettype none
package pvrb_pkg;

  // selector decode
  localparam int unsigned SEL_W     = 16;
  localparam int unsigned IDX_W     = 4;
  localparam int unsigned BASE_W    = 12;
  localparam logic [11:0] SEL_BASE  = 12'h200;

  // word widths
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned DWORD_W   = 64;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned CNT_W     = 5;

  // version register population per level
  localparam int LVL_NONE           = 0;
  localparam int LVL_BASIC          = 1;
  localparam int LVL_FULL           = 2;
  localparam int unsigned NUM_NONE  = 0;
  localparam int unsigned NUM_BASIC = 1;
  localparam int unsigned NUM_FULL  = 13;

  // build options that shape the read path
  localparam int DATA_NARROW        = 32;
  localparam int DATA_WIDE          = 64;
  localparam int ADDR_NARROW_MAX    = 32;
  localparam int MMU_NONE           = 0;
  localparam int MMU_FULL           = 3;
  localparam int MUL_NONE           = 0;
  localparam int FPU_NONE           = 0;

  // register numbers with special read treatment
  localparam logic [3:0] IDX_FEATURES   = 4'h0;
  localparam logic [3:0] IDX_USER       = 4'h1;
  localparam logic [3:0] IDX_PAE_LO     = 4'h6;
  localparam logic [3:0] IDX_PAE_HI     = 4'h7;
  localparam logic [3:0] IDX_AEXT_LO    = 4'h8;
  localparam logic [3:0] IDX_AEXT_HI    = 4'h9;
  localparam logic [3:0] IDX_WIDE_EXTRA = 4'hc;

  // feature word bit positions, position 0 is the msb
  localparam int unsigned POS_CFG     = 0;
  localparam int unsigned POS_BARREL  = 1;
  localparam int unsigned POS_DIV     = 2;
  localparam int unsigned POS_MUL     = 3;
  localparam int unsigned POS_FPU     = 4;
  localparam int unsigned POS_TRAPS   = 5;
  localparam int unsigned POS_ICACHE  = 6;
  localparam int unsigned POS_DCACHE  = 7;
  localparam int unsigned POS_MMU     = 8;
  localparam int unsigned POS_BTC     = 9;
  localparam int unsigned POS_ENDIAN  = 10;
  localparam int unsigned POS_FT      = 11;
  localparam int unsigned POS_STACK_GUARD_FLAG   = 12;
  localparam int unsigned POS_BYTE_SWAP_INSTR_FLAG   = 13;
  localparam int unsigned POS_WIDE    = 14;
  localparam int unsigned POS_RSVD    = 15;
  localparam int unsigned POS_RELEASE = 16;
  localparam int unsigned POS_USER_A  = 24;
  localparam int unsigned FLAG_CNT    = 16;
  localparam int unsigned WIDE_POS_OFFSET = 32;

  // fixed field values
  localparam logic ENDIAN_LITTLE = 1'b1;
  localparam logic RSVD_VALUE    = 1'b0;

endpackage
`default_nettype wire

// File: pvrb_word0_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pvrb_word0_if;
  import pvrb_pkg::*;
  logic [FLAG_CNT-1:0] flags;
  logic [BYTE_W-1:0]   release_code;
  logic [BYTE_W-1:0]   custom_value_a;
  logic [WORD_W-1:0]   word;

  modport builder (output flags, output release_code, output custom_value_a, input word);
  modport packer  (input flags, input release_code, input custom_value_a, output word);
endinterface
`default_nettype wire

// File: pvrb_word0_pack.sv
`timescale 1ns/100ps
`default_nettype none
module pvrb_word0_pack
  import pvrb_pkg::*;
(
  pvrb_word0_if.packer f
);

  // flag at position p lands on bit (msb - p); msb-first numbering
  for (genvar p = 0; p < FLAG_CNT; p++) begin : g_flag
    assign f.word[WORD_W-1-p] = f.flags[p];
  end

  // byte fields keep their own bit order, msb at the lower position
  assign f.word[WORD_W-1-POS_RELEASE -: BYTE_W] = f.release_code;
  assign f.word[WORD_W-1-POS_USER_A -: BYTE_W]  = f.custom_value_a;

endmodule
`default_nettype wire

// File: tb_processor_version_registers.sv
`timescale 1ns/100ps
`default_nettype none
module tb_processor_version_registers
  import pvrb_pkg::*;
();
  // arbitrary build values, chosen only to be recognisable on the bus
  localparam logic [7:0]  REL_CODE = 8'h3c;
  localparam logic [7:0]  USR_A    = 8'ha7;
  localparam logic [31:0] USR_B    = 32'hc3e1_5a09;
  // option levels of the narrow full build; the wide build leaves them at none
  localparam int          ADDR_W_EXT = 40;
  localparam int          MUL_LVL    = 1;
  localparam int          FPU_LVL    = 2;
  // option groups: the narrow build takes a, the wide build the opposite, so
  // every presence bit is seen both set and clear
  localparam bit          OPT_A      = 1'b1;
  localparam bit          OPT_B      = 1'b0;

  // registers two to twelve carry their number in both halves
  function automatic logic [63:0] reg_val(int n);
    return {8'h9e, 8'(n), 16'h1234, 8'h6b, 8'(n), 16'h0c3d};
  endfunction

  function automatic logic [11*DWORD_W-1:0] other_mk();
    logic [11*DWORD_W-1:0] v;
    for (int n = 2; n < 13; n++) begin
      v[(n-2)*64 +: 64] = reg_val(n);
    end
    return v;
  endfunction

  localparam logic [11*DWORD_W-1:0] OTHER = other_mk();

  logic               clk;
  logic               rst_n;
  logic               rd_req;
  logic               rd_ext;
  logic [SEL_W-1:0]   sel;
  logic [3:0]         vld;
  logic [3:0]         hit;
  logic [3:0]         stat;
  logic [DWORD_W-1:0] dat [4];
  logic [DWORD_W-1:0] last [4];
  int                 err_total;
  int                 samples_checked;

  // 0: full level, narrow data, wide address, full mmu
  pvrb_bank #(.VERSION_REGS_LEVEL(LVL_FULL), .ADDR_WIDTH(ADDR_W_EXT), .MEM_MGMT_LEVEL(MMU_FULL),
    .HAS_BARREL_SHIFTER(OPT_A), .HAS_DIVIDER(OPT_B), .HW_MUL_LEVEL(MUL_LVL),
    .FLOAT_UNIT_LEVEL(FPU_LVL), .HAS_INSTR_CACHE(OPT_A), .HAS_DATA_CACHE(OPT_B),
    .HAS_BRANCH_TARGET_CACHE(OPT_A), .FAULT_TOLERANT_FLAG(OPT_B), .STACK_GUARD_FLAG(OPT_A),
    .BYTE_SWAP_INSTR_FLAG(OPT_B), .RELEASE_CODE(REL_CODE),
    .CUSTOM_VALUE_A_PARAM(USR_A), .CUSTOM_VALUE_B_PARAM(USR_B), .OTHER_REGS_VALUE(OTHER)) dut (
    .clk(clk), .rst_n(rst_n), .rd_req(rd_req), .rd_ext(rd_ext), .special_reg_selector(sel),
    .rd_valid(vld[0]), .rd_hit(hit[0]), .rd_data(dat[0]), .status_version_present_bit(stat[0]));
  // 1: basic level, traps only
  pvrb_bank #(.VERSION_REGS_LEVEL(LVL_BASIC), .USES_ANY_TRAPS(OPT_A), .RELEASE_CODE(REL_CODE),
    .CUSTOM_VALUE_A_PARAM(USR_A), .CUSTOM_VALUE_B_PARAM(USR_B), .OTHER_REGS_VALUE(OTHER)) dut_basic (
    .clk(clk), .rst_n(rst_n), .rd_req(rd_req), .rd_ext(rd_ext), .special_reg_selector(sel),
    .rd_valid(vld[1]), .rd_hit(hit[1]), .rd_data(dat[1]), .status_version_present_bit(stat[1]));
  // 2: no version registers at all
  pvrb_bank #(.VERSION_REGS_LEVEL(LVL_NONE), .RELEASE_CODE(REL_CODE),
    .CUSTOM_VALUE_A_PARAM(USR_A), .CUSTOM_VALUE_B_PARAM(USR_B), .OTHER_REGS_VALUE(OTHER)) dut_none (
    .clk(clk), .rst_n(rst_n), .rd_req(rd_req), .rd_ext(rd_ext), .special_reg_selector(sel),
    .rd_valid(vld[2]), .rd_hit(hit[2]), .rd_data(dat[2]), .status_version_present_bit(stat[2]));
  // 3: full level, 64-bit data
  pvrb_bank #(.VERSION_REGS_LEVEL(LVL_FULL), .DATA_WIDTH(DATA_WIDE),
    .HAS_BARREL_SHIFTER(OPT_B), .HAS_DIVIDER(OPT_A), .HAS_INSTR_CACHE(OPT_B),
    .HAS_DATA_CACHE(OPT_A), .HAS_BRANCH_TARGET_CACHE(OPT_B), .FAULT_TOLERANT_FLAG(OPT_A),
    .STACK_GUARD_FLAG(OPT_B), .BYTE_SWAP_INSTR_FLAG(OPT_A), .RELEASE_CODE(REL_CODE),
    .CUSTOM_VALUE_A_PARAM(USR_A), .CUSTOM_VALUE_B_PARAM(USR_B), .OTHER_REGS_VALUE(OTHER)) dut_wide (
    .clk(clk), .rst_n(rst_n), .rd_req(rd_req), .rd_ext(rd_ext), .special_reg_selector(sel),
    .rd_valid(vld[3]), .rd_hit(hit[3]), .rd_data(dat[3]), .status_version_present_bit(stat[3]));

  // feature word, position 0 at the msb
  // a: barrel, multiplier, float, icache, branch cache, stack guard
  // b: divider, dcache, fault tolerance, byte swap
  function automatic logic [31:0] fw(logic full, logic wide, logic a, logic b, logic has_mem_manager,
                                     logic trap);
    return {full, a, b, a, a, trap | has_mem_manager, a, b, has_mem_manager, a, 1'b1, b,
            a, b, wide, 1'b0, REL_CODE, USR_A};
  endfunction

  // expected {hit, data} for instance k
  function automatic logic [DWORD_W:0] expect_rd(int k, logic [SEL_W-1:0] s, logic e);
    int          n;
    int          cnt;
    logic        full;
    logic        a;
    logic        b;
    logic [63:0] v;
    logic [63:0] r;
    n = s[3:0];
    full = (k == 0 || k == 3);
    a = (k == 0) ? OPT_A : (k == 3) ? OPT_B : 1'b0;
    b = (k == 0) ? OPT_B : (k == 3) ? OPT_A : 1'b0;
    cnt = (k == 1) ? 1 : (k == 2) ? 0 : 13;
    v = reg_val(n);
    if (s[15:4] != SEL_BASE || n >= cnt) return '0;
    if (n == 0) r = e ? 64'h0 : {32'h0, fw(full, k == 3, a, b, k == 0, k == 1 && OPT_A)};
    else if (n == 1) r = e ? 64'h0 : {32'h0, USR_B};
    else if (!e) r = (k == 3 && n inside {[6:9], 12}) ? v : {32'h0, v[31:0]};
    else r = (k == 0 && n >= 6 && n <= 9) ? {32'h0, v[63:32]} : 64'h0;
    return {1'b1, r};
  endfunction

  task automatic chk_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %0b seen %0b", what, exp, got);
    end
  endtask

  task automatic chk_word(string what, logic [DWORD_W-1:0] exp, logic [DWORD_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one read, answer checked on the next falling edge
  task automatic rd(logic [SEL_W-1:0] s, logic e);
    logic [DWORD_W:0] x;
    rd_req = 1'b1;
    sel = s;
    rd_ext = e;
    @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      x = expect_rd(k, s, e);
      chk_bit($sformatf("valid%0d", k), 1'b1, vld[k]);
      chk_bit($sformatf("hit%0d", k), x[DWORD_W], hit[k]);
      chk_word($sformatf("data%0d", k), x[DWORD_W-1:0], dat[k]);
      last[k] = x[DWORD_W-1:0];
    end
  endtask

  // no request: valid drops, data holds, noise on the selector
  task automatic idle(int cyc);
    rd_req = 1'b0;
    sel = 16'($urandom);
    rd_ext = 1'($urandom);
    repeat (cyc) begin
      @(negedge clk);
      for (int k = 0; k < 4; k++) begin
        chk_bit($sformatf("valid%0d", k), 1'b0, vld[k]);
        chk_bit($sformatf("hit%0d", k), 1'b0, hit[k]);
        chk_word($sformatf("data%0d", k), last[k], dat[k]);
      end
    end
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    rd_req = 1'b0;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 4; k++) begin
      last[k] = '0;
      chk_bit($sformatf("status%0d", k), k != 2, stat[k]);
    end
    rst_n = 1'b1;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("ERROR watchdog expected finish seen hang");
    close_out();
  end

  initial begin
    logic [SEL_W-1:0] s;
    err_total = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    rd_req = 1'b0;
    rd_ext = 1'b0;
    sel = '0;
    void'($urandom(32'h6841));
    do_reset();
    idle(1);
    // every register number, both read kinds, back to back
    for (int e = 0; e < 2; e++) begin
      for (int n = 0; n < 16; n++) begin
        rd({SEL_BASE, 4'(n)}, e[0]);
      end
    end
    // foreign selector bases must miss
    rd({12'h201, 4'h0}, 1'b0);
    rd({12'h000, 4'h1}, 1'b0);
    rd({12'hf20, 4'h0}, 1'b0);
    rd({12'h100, 4'h8}, 1'b1);
    idle(2);
    // random traffic, mostly on the version base
    repeat (400) begin
      s = 16'($urandom);
      if ($urandom_range(7) != 0) s[15:4] = SEL_BASE;
      rd(s, 1'($urandom));
      if ($urandom_range(3) == 0) idle(1);
    end
    // reset in mid-run leaves contents untouched
    idle(1);
    do_reset();
    idle(1);
    rd({SEL_BASE, 4'h0}, 1'b0);
    rd({SEL_BASE, 4'h1}, 1'b0);
    rd({SEL_BASE, 4'h9}, 1'b1);
    idle(1);
    close_out();
  end
endmodule
`default_nettype wire
